// ==== rtl/status_irq_watchdog_pkg.sv ====
package status_irq_watchdog_pkg;
    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 8;
    localparam int PIN_COUNT   = 7;
    localparam int SLOT_COUNT  = 8;
    localparam int GAP_SLOT    = 4;
    localparam int GROUP_COUNT = 5;
    localparam int SRC_COUNT   = GROUP_COUNT * DATA_W;
    localparam int WDOG_SRC    = 32;
    localparam logic [12:0] ADDR_UPDATE  = 13'h000F;
    localparam logic [12:0] ADDR_MODE_A  = 13'h0100;
    localparam logic [12:0] ADDR_MODE_B  = 13'h0101;
    localparam logic [12:0] ADDR_FUNC_LO = 13'h0103;
    localparam logic [12:0] ADDR_FUNC_HI = 13'h010A;
    localparam logic [12:0] ADDR_WD_LOW  = 13'h010D;
    localparam logic [12:0] ADDR_WD_HIGH = 13'h010E;
    localparam logic [12:0] ADDR_MASK_LO = 13'h010F;
    localparam logic [12:0] ADDR_MASK_HI = 13'h0113;
    localparam logic [12:0] ADDR_CLR_GRP = 13'h0A05;
    localparam logic [12:0] ADDR_CLR_LO  = 13'h0A06;
    localparam logic [12:0] ADDR_CLR_HI  = 13'h0A0A;
    localparam logic [12:0] ADDR_MON_LO  = 13'h0D08;
    localparam logic [12:0] ADDR_MON_HI  = 13'h0D0C;
    localparam int UPDATE_BIT     = 0;
    localparam int CLR_ALL_BIT    = 0;
    localparam int WD_RESTART_BIT = 7;
    localparam int FUNC_DIR_BIT   = 7;
    localparam logic [7:0]  REG_RESET = 8'h00;
    localparam logic [15:0] WD_OFF    = 16'h0000;
    localparam logic [6:0] FN_OUT_IRQ_ALL = 7'h00;
    localparam logic [6:0] FN_OUT_GROUP0  = 7'h01;
    localparam logic [6:0] FN_OUT_WDOG    = 7'h06;
    localparam logic [6:0] FN_IN_CLR_IRQ  = 7'h01;
    localparam logic [6:0] FN_IN_RESTART  = 7'h02;
    localparam logic [6:0] FN_IN_UPDATE   = 7'h03;
    localparam int IN_FN_COUNT = 3;
    localparam int CLK_NS      = 10;
    localparam int MS_NS       = 1000000;
    localparam int MS_CYCLES   = MS_NS / CLK_NS;
    localparam int PULSE_CYCLES = 96;

    typedef enum logic [1:0] {
        MODE_CMOS_HIGH = 2'h0,
        MODE_CMOS_LOW  = 2'h1,
        MODE_OD_HIGH   = 2'h2,
        MODE_OD_LOW    = 2'h3
    } pin_mode_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [12:0]       addr;
        logic [7:0]        wdata;
    } reg_req_t;
endpackage

// ==== rtl/status_irq_watchdog_pins.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_irq_watchdog_pins #(
    parameter int TICK_CYCLES = status_irq_watchdog_pkg::MS_CYCLES
) (
    input  wire logic                              clk_sys,
    input  wire logic                              resetn,
    input  wire status_irq_watchdog_pkg::reg_req_t reg_req,
    output var  logic [7:0]                        reg_rdata,
    output var  logic                              reg_rvalid,
    input  wire logic [39:0]                       irq_src,
    input  wire logic [6:0]                        multi_pin_in,
    output var  logic [6:0]                        multi_pin_out,
    output var  logic [6:0]                        multi_pin_oe_n,
    output var  logic                              update_pulse
);
    import status_irq_watchdog_pkg::*;

    localparam int PRE_W = $clog2(TICK_CYCLES);

    // ==========================================================
    // Reset release.
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ==========================================================
    // Register decode.
    logic [7:0]  mode_a_reg, mode_b_reg, wd_low_reg, wd_high_reg;
    logic [7:0]  func_reg [SLOT_COUNT];
    logic [7:0]  mask_reg [GROUP_COUNT];
    logic [7:0]  act_mode_a_reg, act_mode_b_reg;
    logic [7:0]  act_func_reg [SLOT_COUNT];
    logic [15:0] act_period_reg;
    logic [SLOT_COUNT-1:0] pend_reg;
    logic [SRC_COUNT-1:0]  mon_reg, qual_q_reg;
    logic        wr_update, clr_all_wr, restart_wr, wr_func, wr_mask, wr_clr;
    logic [2:0]  func_slot, grp_idx, clr_idx, mon_idx;
    logic [IN_FN_COUNT:1] in_fn;
    logic        upd_q_reg;
    logic        update;

    always_comb
    begin
        wr_update  = reg_req.wr && reg_req.addr == ADDR_UPDATE
                     && reg_req.wdata[UPDATE_BIT];
        clr_all_wr = reg_req.wr && reg_req.addr == ADDR_CLR_GRP
                     && reg_req.wdata[CLR_ALL_BIT];
        restart_wr = reg_req.wr && reg_req.addr == ADDR_CLR_GRP
                     && reg_req.wdata[WD_RESTART_BIT];
        wr_func    = reg_req.wr && reg_req.addr >= ADDR_FUNC_LO
                     && reg_req.addr <= ADDR_FUNC_HI;
        wr_mask    = reg_req.wr && reg_req.addr >= ADDR_MASK_LO
                     && reg_req.addr <= ADDR_MASK_HI;
        wr_clr     = reg_req.wr && reg_req.addr >= ADDR_CLR_LO
                     && reg_req.addr <= ADDR_CLR_HI;
        func_slot  = 3'(reg_req.addr - ADDR_FUNC_LO);
        grp_idx    = 3'(reg_req.addr - ADDR_MASK_LO);
        clr_idx    = 3'(reg_req.addr - ADDR_CLR_LO);
        mon_idx    = 3'(reg_req.addr - ADDR_MON_LO);
        // Update bit self-clears: it is never stored.
        update     = wr_update || (in_fn[3] && !upd_q_reg);
    end

    // ==========================================================
    // Buffered settings, written by the host.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_a_reg  <= REG_RESET;
            mode_b_reg  <= REG_RESET;
            wd_low_reg  <= REG_RESET;
            wd_high_reg <= REG_RESET;
            for (int s = 0; s < SLOT_COUNT; s++)
                func_reg[s] <= REG_RESET;
            for (int g = 0; g < GROUP_COUNT; g++)
                mask_reg[g] <= REG_RESET;
        end
        else
        begin
            if (reg_req.wr && reg_req.addr == ADDR_MODE_A)
                mode_a_reg <= reg_req.wdata;
            if (reg_req.wr && reg_req.addr == ADDR_MODE_B)
                mode_b_reg <= reg_req.wdata;
            if (reg_req.wr && reg_req.addr == ADDR_WD_LOW)
                wd_low_reg <= reg_req.wdata;
            if (reg_req.wr && reg_req.addr == ADDR_WD_HIGH)
                wd_high_reg <= reg_req.wdata;
            if (wr_func)
                func_reg[func_slot] <= reg_req.wdata;
            // Masks act at once; clearing one never touches the monitor.
            if (wr_mask)
                mask_reg[grp_idx] <= reg_req.wdata;
        end
    end

    // ==========================================================
    // Active copies and pin hold-off on reconfiguration.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_mode_a_reg <= REG_RESET;
            act_mode_b_reg <= REG_RESET;
            act_period_reg <= WD_OFF;
            for (int s = 0; s < SLOT_COUNT; s++)
                act_func_reg[s] <= REG_RESET;
        end
        else if (update)
        begin
            act_mode_a_reg <= mode_a_reg;
            act_mode_b_reg <= mode_b_reg;
            act_period_reg <= {wd_high_reg, wd_low_reg};
            for (int s = 0; s < SLOT_COUNT; s++)
                act_func_reg[s] <= func_reg[s];
        end
    end

    // A new write wins over an update in the same cycle, so a pin never
    // runs a half-applied setting.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pend_reg <= '0;
        else
            for (int s = 0; s < SLOT_COUNT; s++)
                if ((wr_func && func_slot == 3'(s))
                    || (reg_req.wr && reg_req.addr == ADDR_MODE_A && s < 4)
                    || (reg_req.wr && reg_req.addr == ADDR_MODE_B && s >= 4))
                    pend_reg[s] <= 1'b1;
                else if (update)
                    pend_reg[s] <= 1'b0;
    end

    // ==========================================================
    // Pin input filtering: three stages, a change counts when the
    // second and third agree.
    logic [6:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg  <= '0;
            pin_s2_reg  <= '0;
            pin_s3_reg  <= '0;
            pin_lvl_reg <= '0;
            upd_q_reg   <= 1'b0;
        end
        else
        begin
            pin_s1_reg <= multi_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < PIN_COUNT; i++)
                if (pin_s2_reg[i] == pin_s3_reg[i])
                    pin_lvl_reg[i] <= pin_s3_reg[i];
            upd_q_reg <= in_fn[3];
        end
    end

    // ==========================================================
    // Pin functions. Pin numbering skips the absent fifth slot.
    logic [SRC_COUNT-1:0] mon_grp_or;
    logic [GROUP_COUNT-1:0] grp_any;
    logic       wd_stretch;
    logic [6:0] out_next, oe_n_next, pin_assert;
    logic [IN_FN_COUNT:1] and_all, or_any, or_used, used;
    always_comb
    begin
        int s;
        logic [1:0] md;
        logic [7:0] fn;
        logic       lvl;
        s = 0;
        md = '0;
        fn = '0;
        lvl = 1'b0;
        mon_grp_or = mon_reg;
        for (int g = 0; g < GROUP_COUNT; g++)
            grp_any[g] = |mon_reg[g*DATA_W +: DATA_W];
        and_all = '1;
        or_any  = '0;
        or_used = '0;
        used    = '0;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            s   = (i < GAP_SLOT) ? i : i + 1;
            fn  = act_func_reg[s];
            md  = (s < 4) ? act_mode_a_reg[2*s +: 2]
                          : act_mode_b_reg[2*(s-4) +: 2];
            pin_assert[i] = 1'b0;
            if (fn[FUNC_DIR_BIT])
            begin
                if (fn[6:0] == FN_OUT_IRQ_ALL)
                    pin_assert[i] = |mon_grp_or;
                else if (fn[6:0] == FN_OUT_WDOG)
                    pin_assert[i] = wd_stretch;
                else
                    for (int g = 0; g < GROUP_COUNT; g++)
                        if (fn[6:0] == 7'(FN_OUT_GROUP0 + g))
                            pin_assert[i] = grp_any[g];
            end
            out_next[i]  = 1'b0;
            oe_n_next[i] = 1'b1;
            if (fn[FUNC_DIR_BIT] && !pend_reg[s])
                unique case (pin_mode_t'(md))
                    MODE_CMOS_HIGH:
                    begin
                        out_next[i]  = pin_assert[i];
                        oe_n_next[i] = 1'b0;
                    end
                    MODE_CMOS_LOW:
                    begin
                        out_next[i]  = !pin_assert[i];
                        oe_n_next[i] = 1'b0;
                    end
                    MODE_OD_HIGH:
                    begin
                        out_next[i]  = 1'b1;
                        oe_n_next[i] = !pin_assert[i];
                    end
                    MODE_OD_LOW:
                    begin
                        out_next[i]  = 1'b0;
                        oe_n_next[i] = !pin_assert[i];
                    end
                endcase
            lvl = md[0] ? !pin_lvl_reg[i] : pin_lvl_reg[i];
            for (int k = 1; k <= IN_FN_COUNT; k++)
                if (!fn[FUNC_DIR_BIT] && !pend_reg[s] && fn[6:0] == 7'(k))
                begin
                    used[k] = 1'b1;
                    if (md[1])
                    begin
                        or_any[k]  = or_any[k] | lvl;
                        or_used[k] = 1'b1;
                    end
                    else
                        and_all[k] = and_all[k] & lvl;
                end
        end
        in_fn = used & and_all & (or_any | ~or_used);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            multi_pin_out  <= '0;
            multi_pin_oe_n <= '1;
            update_pulse   <= 1'b0;
        end
        else
        begin
            multi_pin_out  <= out_next;
            multi_pin_oe_n <= oe_n_next;
            update_pulse   <= update;
        end
    end

    // ==========================================================
    // Interrupt monitor. Masked sources are edge detected, so a mask
    // enabled over a standing condition still produces an edge.
    logic [SRC_COUNT-1:0] src_vec, mask_vec, qual, rise, clr_vec;
    logic wd_timeout, clr_all;
    always_comb
    begin
        src_vec = irq_src;
        src_vec[WDOG_SRC] = irq_src[WDOG_SRC] | wd_timeout;
        clr_vec = '0;
        for (int g = 0; g < GROUP_COUNT; g++)
        begin
            mask_vec[g*DATA_W +: DATA_W] = mask_reg[g];
            if (wr_clr && clr_idx == 3'(g))
                clr_vec[g*DATA_W +: DATA_W] = reg_req.wdata;
        end
        qual    = src_vec & mask_vec;
        rise    = qual & ~qual_q_reg;
        clr_all = clr_all_wr || in_fn[1];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mon_reg    <= '0;
            qual_q_reg <= '0;
        end
        else
        begin
            qual_q_reg <= qual;
            // A new edge wins over any clear in the same cycle.
            mon_reg <= rise | (mon_reg & ~clr_vec & ~{SRC_COUNT{clr_all}});
        end
    end

    // ==========================================================
    // Readback of buffered settings and live monitor bits.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_req.rd;
            reg_rdata  <= '0;
            if (reg_req.rd)
            begin
                if (reg_req.addr == ADDR_MODE_A)
                    reg_rdata <= mode_a_reg;
                else if (reg_req.addr == ADDR_MODE_B)
                    reg_rdata <= mode_b_reg;
                else if (reg_req.addr == ADDR_WD_LOW)
                    reg_rdata <= wd_low_reg;
                else if (reg_req.addr == ADDR_WD_HIGH)
                    reg_rdata <= wd_high_reg;
                else if (reg_req.addr >= ADDR_FUNC_LO
                         && reg_req.addr <= ADDR_FUNC_HI)
                    reg_rdata <= func_reg[func_slot];
                else if (reg_req.addr >= ADDR_MASK_LO
                         && reg_req.addr <= ADDR_MASK_HI)
                    reg_rdata <= mask_reg[grp_idx];
                else if (reg_req.addr >= ADDR_MON_LO
                         && reg_req.addr <= ADDR_MON_HI)
                    reg_rdata <= mon_reg[mon_idx*DATA_W +: DATA_W];
            end
        end
    end

    // ==========================================================
    // Watchdog. Restart and period change both zero the count.
    logic [PRE_W-1:0] pre_reg;
    logic [15:0]      ms_reg;
    logic [6:0]       stretch_reg;
    logic             restart, tick;
    always_comb
    begin
        restart    = restart_wr || in_fn[2] || update;
        tick       = pre_reg == PRE_W'(TICK_CYCLES - 1);
        wd_timeout = act_period_reg != WD_OFF && !restart && tick
                     && ms_reg == act_period_reg - 16'h0001;
        wd_stretch = stretch_reg != '0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_reg <= '0;
            ms_reg  <= '0;
        end
        else if (restart || act_period_reg == WD_OFF)
        begin
            pre_reg <= '0;
            ms_reg  <= '0;
        end
        else if (tick)
        begin
            pre_reg <= '0;
            ms_reg  <= wd_timeout ? '0 : ms_reg + 16'h0001;
        end
        else
            pre_reg <= pre_reg + PRE_W'(1);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stretch_reg <= '0;
        else if (wd_timeout)
            stretch_reg <= 7'(PULSE_CYCLES);
        else if (stretch_reg != '0)
            stretch_reg <= stretch_reg - 7'h01;
    end

    // ==========================================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_CMOS_HIGH: assert property (!pend_reg[0] && act_func_reg[0][7]
        && act_mode_a_reg[1:0] == 2'h0 |=> !multi_pin_oe_n[0]
        && multi_pin_out[0] == $past(pin_assert[0]))
        else $error("Active high pin level wrong.");
    AST_OD_FLOAT: assert property (!pend_reg[0] && act_mode_a_reg[1]
        && !pin_assert[0] |=> multi_pin_oe_n[0])
        else $error("Open drain pin not floating.");
    AST_HOLD_OFF: assert property (pend_reg[1] && !update
        |=> pend_reg[1] && multi_pin_oe_n[1])
        else $error("Pin ran before update.");
    AST_MON_SET: assert property (src_vec[0] && mask_vec[0]
        && !qual_q_reg[0] |=> mon_reg[0])
        else $error("Monitor bit not set.");
    AST_MASK_KEEP: assert property (mon_reg[0] && !clr_vec[0] && !clr_all
        |=> mon_reg[0])
        else $error("Monitor bit lost.");
    AST_EDGE_ONLY: assert property (!mon_reg[0] && qual_q_reg[0]
        |=> !mon_reg[0])
        else $error("Level set monitor bit.");
    AST_CLR_ALL: assert property (clr_all
        |=> (mon_reg & ~$past(rise)) == '0)
        else $error("Clear all missed a bit.");
    AST_WD_PULSE: assert property (wd_timeout
        |=> wd_stretch[*8] ##88 wd_stretch ##1 !wd_stretch || wd_timeout)
        else $error("Watchdog pulse width wrong.");
    AST_WD_RESTART: assert property (restart_wr
        |=> !wd_timeout ##1 !wd_timeout)
        else $error("Timeout right after restart.");
    AST_UPDATE: assert property (wr_update
        |=> act_period_reg == $past({wd_high_reg, wd_low_reg}))
        else $error("Update did not copy period.");
endmodule
`default_nettype wire

// ==== tb/board_pins.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Board side of the multifunction pins.
module board_pins (
    input  wire logic [6:0] pin_out,
    input  wire logic [6:0] pin_oe_n,
    input  wire logic [6:0] drive_en,
    input  wire logic [6:0] drive_val,
    output var  logic [6:0] pin_level
);
    // A released pin is never left holding its last value.
    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (drive_en[i])
                pin_level[i] = drive_val[i];
            else
                pin_level[i] = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/status_irq_watchdog_pins_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_irq_watchdog_pins_test;
    import status_irq_watchdog_pkg::*;
    // ============================================================
    // Clock, reset and stimulus.
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    reg_req_t    req = '0;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [39:0] irq_src = '0;
    logic [6:0]  pin_level;
    logic [6:0]  pin_out;
    logic [6:0]  pin_oe_n;
    logic [6:0]  drive_en = '0;
    logic [6:0]  drive_val = '0;
    int          fail_count = 0;
    int          total_checks = 0;
    int          n;
    int          w;
    logic        upd_pulse;
    int          upd_count = 0;
    always #5 clk_sys = ~clk_sys;

    // The update pulse stands one cycle, so the falling edge sees it once.
    always @(negedge clk_sys)
        if (upd_pulse === 1'b1)
            upd_count++;

    // A short tick keeps the watchdog periods to a few hundred cycles.
    status_irq_watchdog_pins #(.TICK_CYCLES(10)) i_status_irq_watchdog_pins (
        .clk_sys(clk_sys), .resetn(resetn), .reg_req(req),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .irq_src(irq_src),
        .multi_pin_in(pin_level), .multi_pin_out(pin_out),
        .multi_pin_oe_n(pin_oe_n), .update_pulse(upd_pulse));
    board_pins i_board_pins (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive_en(drive_en),
        .drive_val(drive_val), .pin_level(pin_level));

    // ============================================================
    // Access and compare tasks.
    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_n(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] got;
        got = 'x;
        @(negedge clk_sys);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_sys);
        req.rd = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if (rvalid === 1'b1)
                got = rdata;
            @(negedge clk_sys);
        end
        check8("reg_rdata", exp, got);
    endtask
    task automatic chk_pin(input int p, input logic oe, input logic out);
        check8("pin_oe_n", {7'h0, oe}, {7'h0, pin_oe_n[p]});
        if (!oe)
            check8("pin_out", {7'h0, out}, {7'h0, pin_out[p]});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ============================================================
    // Tests.
    initial
    begin
        wait_n(5);
        resetn = 1'b1;
        wait_n(4);
        rd(ADDR_MODE_A, 8'h00);
        rd(13'h0200, 8'h00);
        wr(ADDR_FUNC_LO, 8'h81);
        wr(13'h0104, 8'h01);
        wr(13'h0105, 8'h86);
        wr(13'h0108, 8'h80);
        wr(13'h0109, 8'h03);
        wr(ADDR_MODE_A, 8'h08);
        wr(ADDR_UPDATE, 8'h01);
        rd(ADDR_UPDATE, 8'h00);
        chk_pin(0, 1'b0, 1'b0);
        wr(ADDR_MASK_LO, 8'h01);
        irq_src[0] = 1'b1;
        wait_n(4);
        rd(ADDR_MON_LO, 8'h01);
        chk_pin(0, 1'b0, 1'b1);
        chk_pin(4, 1'b0, 1'b1);
        wr(ADDR_MASK_LO, 8'h00);
        rd(ADDR_MON_LO, 8'h01);
        wr(ADDR_CLR_LO, 8'h01);
        wait_n(3);
        rd(ADDR_MON_LO, 8'h00);
        rd(ADDR_CLR_LO, 8'h00);
        chk_pin(0, 1'b0, 1'b0);
        chk_pin(4, 1'b0, 1'b0);
        wr(ADDR_MASK_LO, 8'h01);
        wait_n(4);
        rd(ADDR_MON_LO, 8'h01);
        // Every pin mode, asserted then deasserted.
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_MODE_A, {4'h0, 2'h2, m[1:0]});
            wait_n(2);
            chk_pin(0, 1'b1, 1'b0);
            wr(ADDR_UPDATE, 8'h01);
            wait_n(3);
            chk_pin(0, 1'b0, !m[0]);
            wr(ADDR_CLR_GRP, 8'h01);
            wait_n(3);
            chk_pin(0, m[1], m[0]);
            irq_src[0] = 1'b0;
            wait_n(2);
            irq_src[0] = 1'b1;
            wait_n(4);
            rd(ADDR_MON_LO, 8'h01);
        end
        rd(ADDR_CLR_GRP, 8'h00);
        wr(ADDR_MODE_A, 8'h08);
        wr(ADDR_UPDATE, 8'h01);
        drive_en[1] = 1'b1;
        drive_val[1] = 1'b1;
        wait_n(8);
        rd(ADDR_MON_LO, 8'h00);
        drive_val[1] = 1'b0;
        irq_src[0] = 1'b0;
        wait_n(8);
        irq_src[0] = 1'b1;
        wait_n(4);
        rd(ADDR_MON_LO, 8'h01);
        wr(ADDR_MODE_A, 8'h0c);
        wr(ADDR_UPDATE, 8'h01);
        wait_n(8);
        rd(ADDR_MON_LO, 8'h00);
        // A high level on the inverted clear pin ends the clear-all.
        drive_val[1] = 1'b1;
        // Watchdog of 20 ticks, restarted twice by register and once by
        // a pin before it runs out.
        wr(13'h0106, 8'h02);
        wr(ADDR_WD_LOW, 8'h14);
        wr(ADDR_WD_HIGH, 8'h00);
        wr(ADDR_MASK_HI, 8'h01);
        wr(ADDR_UPDATE, 8'h01);
        repeat (2)
        begin
            wait_n(150);
            wr(ADDR_CLR_GRP, 8'h80);
        end
        wait_n(150);
        drive_en[3] = 1'b1;
        drive_val[3] = 1'b1;
        wait_n(4);
        drive_en[3] = 1'b0;
        rd(ADDR_MON_HI, 8'h00);
        n = 0;
        while (pin_out[2] !== 1'b1 && n < 300)
        begin
            wait_n(1);
            n++;
        end
        w = 0;
        while (pin_out[2] === 1'b1 && w < 200)
        begin
            wait_n(1);
            w++;
        end
        check8("wd_period", 8'h01, {7'h0, n > 185 && n < 205});
        check8("wd_pulse", 8'h60, w[7:0]);
        rd(ADDR_MON_HI, 8'h01);
        wait_n(120);
        chk_pin(2, 1'b0, 1'b1);
        wr(ADDR_WD_LOW, 8'h00);
        wr(ADDR_UPDATE, 8'h01);
        wr(ADDR_CLR_HI, 8'h01);
        wait_n(400);
        rd(ADDR_MON_HI, 8'h00);
        // Update from a pin: the rewritten mode holds M0 off until then.
        wr(ADDR_MODE_A, 8'h0c);
        wait_n(2);
        chk_pin(0, 1'b1, 1'b0);
        drive_en[5] = 1'b1;
        drive_val[5] = 1'b1;
        wait_n(8);
        chk_pin(0, 1'b0, 1'b0);
        check8("update_pulse", 8'h0a, upd_count[7:0]);
        test_done();
    end

    // Runaway guard; the tests need about 1,550 cycles.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
